// *** logic/did_pkg.sv ***
// Shared types and constants for the digital input event dispatcher.
package did_pkg;

  // ==========================================================================
  // Sizes and reset values
  // ==========================================================================
  localparam int         DID_NUM_IN   = 8;
  localparam logic       DID_VPRES_ON = 1'b0;  // voltage_present_on
  localparam logic       DID_VABS_ON  = 1'b1;  // voltage_absent_on
  localparam logic [7:0] DID_MODE_RST = 8'h00;
  localparam logic [7:0] DID_ZERO8    = 8'h00;
  localparam logic [2:0] DID_NUM_RST  = 3'h0;

  // ==========================================================================
  // Input functions
  // ==========================================================================
  typedef enum logic [3:0] {
    FN_NONE      = 4'b0000,
    FN_START     = 4'b0001,
    FN_PAUSE     = 4'b0010,
    FN_RESUME    = 4'b0011,
    FN_TERMINATE = 4'b0100,
    FN_WAIT      = 4'b0101,
    FN_STEP_BACK = 4'b0110,
    FN_STEP_FWD  = 4'b0111,
    FN_CHAM_OFF  = 4'b1000,
    FN_ALL_OFF   = 4'b1001,
    FN_EVT_OFF   = 4'b1010,
    FN_OUT_CTL   = 4'b1011
  } did_func_t;

  // ==========================================================================
  // Profile sequencer state, as reported to this block
  // ==========================================================================
  typedef enum logic [1:0] {
    PROF_IDLE = 2'b00,
    PROF_RUN  = 2'b01,
    PROF_HOLD = 2'b10,
    PROF_WAIT = 2'b11
  } did_prof_t;

  typedef enum logic {
    CFG_IDLE = 1'b0,
    CFG_EDIT = 1'b1
  } did_cfg_state_t;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic start;
    logic pause;
    logic resume;
    logic terminate;
    logic waitRelease;
    logic stepBack;
    logic stepFwd;
  } did_cmd_t;

  typedef struct packed {
    logic chamberOff;
    logic eventOff;
  } did_force_t;

  typedef struct packed {
    logic [2:0] num;
    logic       mode;
    did_func_t  func;
  } did_cfg_t;

  localparam did_cmd_t   DID_CMD_RST   = '0;
  localparam did_force_t DID_FORCE_RST = '0;

endpackage

// *** logic/did_dispatcher.sv ***
// Digital input event dispatcher: edge and level functions for eight inputs.
// ============================================================================
// What this block does
// - Eight independent inputs, each with its function.
// - Per-input trigger transition selects the firing edge.
// - Off-to-on mode fires when voltage is applied.
// - On-to-off mode fires when voltage is removed.
// - Profile functions on edges, output functions on levels.
// - Start edge begins loaded profile from step one.
// - Pause edge puts a running profile on hold.
// - Resume edge returns a held profile to run.
// - Terminate ends active profile; idle means no action.
// - Wait release only for edges after wait entry.
// - Step back/forward only if held before edge.
// - Chamber-off input forces chamber outputs off while on.
// - All-off input forces chamber and event outputs off.
// - Event-off input forces customer event outputs off.
// - Output-control input drives its assigned output level.
// - Trigger setting defines the on level of inputs.
// - Several inputs may share one function.
// - Configuration changes apply only on explicit accept.
// - Assigned output stays off unless output-control function.
`timescale 1ns/10ps

module did_dispatcher
  import did_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Field inputs
  input  wire logic [7:0] rawIn,
  // Profile sequencer status
  input  wire did_prof_t  profState,
  input  wire logic [2:0] waitSel,
  // Configuration editing
  input  wire logic       cfgOpen,
  input  wire logic       cfgStageMode,
  input  wire logic       cfgStageFunc,
  input  wire logic       cfgAccept,
  input  wire logic       cfgLeave,
  input  wire did_cfg_t   cfgReq,
  // Configuration view
  output did_cfg_t        cfgView,
  output logic            cfgEditing,
  // Commands to the sequencer and output drivers
  output did_cmd_t        cmd,
  output did_force_t      forceOff,
  output logic [7:0]      ctrlOut
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [7:0]            sync1;
    logic [7:0]            sync2;
    logic [7:0]            prevOn;
    logic [7:0]            mode;
    did_func_t [7:0]       func;
    did_prof_t             prevProf;
    did_cfg_state_t        cfgState;
    did_cfg_t              stage;
    did_cmd_t              cmd;
    did_force_t            forceOff;
    logic [7:0]            ctrlOut;
  } did_state_t;

  did_state_t s;
  did_state_t next_s;

  logic [7:0] onNow;
  logic [7:0] edgeOn;
  logic       waitArmed;
  logic       heldBefore;
  logic       profActive;

  // The second flop is the only reader of sync1.
  assign onNow  = s.sync2 ^ s.mode;
  assign edgeOn = onNow & ~s.prevOn;

  assign waitArmed  = (profState == PROF_WAIT) && (s.prevProf == PROF_WAIT);
  assign heldBefore = (profState == PROF_HOLD) && (s.prevProf == PROF_HOLD);
  assign profActive = (profState != PROF_IDLE);

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    next_s          = s;
    next_s.sync1    = rawIn;
    next_s.sync2    = s.sync1;
    next_s.prevOn   = onNow;
    next_s.prevProf = profState;
    next_s.cmd      = DID_CMD_RST;
    next_s.forceOff = DID_FORCE_RST;
    next_s.ctrlOut  = DID_ZERO8;

    // Each input is evaluated alone; matching functions simply OR together.
    for (int i = 0; i < DID_NUM_IN; i++) begin
      if (edgeOn[i]) begin
        case (s.func[i])
          FN_START: begin
            next_s.cmd.start = 1'b1;
          end
          FN_PAUSE: begin
            if (profState == PROF_RUN || profState == PROF_WAIT) begin
              next_s.cmd.pause = 1'b1;
            end
          end
          FN_RESUME: begin
            if (profState == PROF_HOLD) begin
              next_s.cmd.resume = 1'b1;
            end
          end
          FN_TERMINATE: begin
            if (profActive) begin
              next_s.cmd.terminate = 1'b1;
            end
          end
          FN_WAIT: begin
            if (waitArmed && waitSel == 3'(i)) begin
              next_s.cmd.waitRelease = 1'b1;
            end
          end
          FN_STEP_BACK: begin
            if (heldBefore) begin
              next_s.cmd.stepBack = 1'b1;
            end
          end
          FN_STEP_FWD: begin
            if (heldBefore) begin
              next_s.cmd.stepFwd = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
      if (onNow[i]) begin
        case (s.func[i])
          FN_CHAM_OFF: begin
            next_s.forceOff.chamberOff = 1'b1;
          end
          FN_ALL_OFF: begin
            next_s.forceOff.chamberOff = 1'b1;
            next_s.forceOff.eventOff   = 1'b1;
          end
          FN_EVT_OFF: begin
            next_s.forceOff.eventOff = 1'b1;
          end
          FN_OUT_CTL: begin
            next_s.ctrlOut[i] = 1'b1;
          end
          default: begin
          end
        endcase
      end
    end

    // Edits sit in a staging copy until accepted, so a half-made setup
    // never reaches the live inputs.
    case (s.cfgState)
      CFG_IDLE: begin
        if (cfgOpen) begin
          next_s.cfgState   = CFG_EDIT;
          next_s.stage.num  = cfgReq.num;
          next_s.stage.mode = s.mode[cfgReq.num];
          next_s.stage.func = s.func[cfgReq.num];
        end
      end
      CFG_EDIT: begin
        if (cfgLeave) begin
          next_s.cfgState = CFG_IDLE;
        end else if (cfgOpen) begin
          next_s.stage.num  = cfgReq.num;
          next_s.stage.mode = s.mode[cfgReq.num];
          next_s.stage.func = s.func[cfgReq.num];
        end else if (cfgAccept) begin
          next_s.mode[s.stage.num] = s.stage.mode;
          next_s.func[s.stage.num] = s.stage.func;
          // Re-base the edge detector so a mode change is not seen as an edge.
          next_s.prevOn[s.stage.num] = s.sync2[s.stage.num] ^ s.stage.mode;
          next_s.cfgState = CFG_IDLE;
        end else begin
          if (cfgStageMode) begin
            next_s.stage.mode = cfgReq.mode;
          end
          if (cfgStageFunc) begin
            next_s.stage.func = cfgReq.func;
          end
        end
      end
      default: begin
        next_s.cfgState = CFG_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s          <= '0;
      s.mode     <= DID_MODE_RST;
      s.cfgState <= CFG_IDLE;
      s.prevProf <= PROF_IDLE;
      s.cmd      <= DID_CMD_RST;
      s.forceOff <= DID_FORCE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign cfgView    = s.stage;
  assign cfgEditing = (s.cfgState == CFG_EDIT);
  assign cmd        = s.cmd;
  assign forceOff   = s.forceOff;
  assign ctrlOut    = s.ctrlOut;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Function masks over all eight inputs, so each check below covers every
  // input rather than one fixed input that a test might never configure.
  logic [7:0] fnStart;
  logic [7:0] fnNone;
  logic [7:0] fnChamOff;
  logic [7:0] fnAllOff;
  logic [7:0] fnEvtOff;
  logic [7:0] fnOutCtl;

  always_comb begin
    for (int k = 0; k < DID_NUM_IN; k++) begin
      fnStart[k]   = (s.func[k] == FN_START);
      fnNone[k]    = (s.func[k] == FN_NONE);
      fnChamOff[k] = (s.func[k] == FN_CHAM_OFF);
      fnAllOff[k]  = (s.func[k] == FN_ALL_OFF);
      fnEvtOff[k]  = (s.func[k] == FN_EVT_OFF);
      fnOutCtl[k]  = (s.func[k] == FN_OUT_CTL);
    end
  end

  start_on_edge_a : assert property (
    (|(edgeOn & fnStart)) |=> cmd.start)
    else $error("start edge did not issue start");

  start_source_a : assert property (
    cmd.start |-> $past(|(edgeOn & fnStart)))
    else $error("start issued with no start edge");

  none_quiet_a : assert property (
    cmd != DID_CMD_RST |-> $past(|(edgeOn & ~fnNone)))
    else $error("command issued with no configured edge");

  pause_when_run_a : assert property (
    cmd.pause |-> $past(profState) inside {PROF_RUN, PROF_WAIT})
    else $error("pause issued while not running");

  resume_from_hold_a : assert property (
    cmd.resume |-> $past(profState) == PROF_HOLD)
    else $error("resume issued while not in hold");

  term_idle_quiet_a : assert property (
    profState == PROF_IDLE |=> !cmd.terminate)
    else $error("terminate issued with no profile");

  wait_after_entry_a : assert property (
    cmd.waitRelease |->
      $past(profState, 1) == PROF_WAIT && $past(profState, 2) == PROF_WAIT)
    else $error("wait released by early transition");

  step_needs_hold_a : assert property (
    (cmd.stepBack || cmd.stepFwd) |->
      $past(profState, 1) == PROF_HOLD && $past(profState, 2) == PROF_HOLD)
    else $error("step moved without prior hold");

  chamber_off_a : assert property (
    (|(onNow & fnChamOff)) |=> forceOff.chamberOff)
    else $error("chamber outputs not forced off");

  chamber_source_a : assert property (
    forceOff.chamberOff |-> $past(|(onNow & (fnChamOff | fnAllOff))))
    else $error("chamber outputs forced off with no input on");

  all_off_a : assert property (
    (|(onNow & fnAllOff)) |=>
      forceOff.chamberOff && forceOff.eventOff)
    else $error("all outputs not forced off");

  event_off_a : assert property (
    forceOff.eventOff |->
      $past(|(onNow & (fnEvtOff | fnAllOff))))
    else $error("event outputs forced off with no input on");

  event_on_a : assert property (
    (|(onNow & fnEvtOff)) |=> forceOff.eventOff)
    else $error("event outputs not forced off");

  event_only_a : assert property (
    (|(onNow & fnEvtOff)) && !(|(onNow & (fnChamOff | fnAllOff))) |=>
      !forceOff.chamberOff)
    else $error("event-off input forced chamber outputs off");

  out_ctl_follow_a : assert property (
    ctrlOut == ($past(onNow) & $past(fnOutCtl)))
    else $error("output control does not follow input");

  out_ctl_only_a : assert property (
    (ctrlOut & ~$past(fnOutCtl)) == DID_ZERO8)
    else $error("assigned output on without output control");

  commit_only_a : assert property (
    $changed(s.func) || $changed(s.mode) |->
      $past(cfgAccept) && $past(s.cfgState) == CFG_EDIT)
    else $error("configuration changed without accept");

  sync_edge_a : assert property (
    (|(onNow & ~$past(onNow) & fnStart)) && $stable(s.mode) |=> cmd.start)
    else $error("synchronised edge missed");

  // Leaving or reselecting must never reach the live configuration, or a
  // half-made setup could fire an input under the wrong function.
  leave_keeps_a : assert property (
    cfgEditing && cfgLeave |=>
      !cfgEditing && $stable(s.func) && $stable(s.mode))
    else $error("leaving the edit changed the configuration");

  reopen_drops_a : assert property (
    cfgEditing && cfgOpen && !cfgLeave |=>
      cfgEditing && cfgView.num == $past(cfgReq.num) && $stable(s.func))
    else $error("selecting another input kept the old edit");

  idle_stage_a : assert property (
    !cfgEditing && !cfgOpen |=> $stable(cfgView))
    else $error("staging changed while not editing");

endmodule

// *** verification/did_contacts.sv ***
// Model of the field contacts that switch the supply onto the inputs.
`timescale 1ns/10ps

module did_contacts
  import did_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Contact commands from the bench
  input  wire logic [7:0] closeReq,
  // Field side
  output logic [7:0]      rawIn
);
  // ======================================
  // Contact switching
  // A closed contact applies the supply and an open one removes it.
  // Contacts move one cycle after the request, as relays never follow
  // the bench instantly.
  initial rawIn = DID_ZERO8;
  always @(posedge clk) begin
    rawIn <= closeReq;
  end
endmodule

// *** verification/did_dispatcher_test.sv ***
// Self-checking bench for the digital input event dispatcher.
`timescale 1ns/10ps

module did_dispatcher_test
  import did_pkg::*;
;
  logic       clk;
  logic       rst_b;
  logic [7:0] closeReq;
  logic [7:0] rawIn;
  did_prof_t  profState;
  logic [2:0] waitSel;
  logic       cfgOpen;
  logic       cfgStageMode;
  logic       cfgStageFunc;
  logic       cfgAccept;
  logic       cfgLeave;
  did_cfg_t   cfgReq;
  did_cfg_t   cfgView;
  logic       cfgEditing;
  did_cmd_t   cmd;
  did_force_t frc;
  logic [7:0] ctrlOut;
  int         failCount;
  int         totalChecks;

  did_contacts i_did_contacts (
    .clk      (clk),
    .closeReq (closeReq),
    .rawIn    (rawIn)
  );

  did_dispatcher i_did_dispatcher (
    .clk          (clk),
    .rst_b        (rst_b),
    .rawIn        (rawIn),
    .profState    (profState),
    .waitSel      (waitSel),
    .cfgOpen      (cfgOpen),
    .cfgStageMode (cfgStageMode),
    .cfgStageFunc (cfgStageFunc),
    .cfgAccept    (cfgAccept),
    .cfgLeave     (cfgLeave),
    .cfgReq       (cfgReq),
    .cfgView      (cfgView),
    .cfgEditing   (cfgEditing),
    .cmd          (cmd),
    .forceOff     (frc),
    .ctrlOut      (ctrlOut)
  );

  // ======================================
  // Checking and closing
  task chk(input logic ok, input string m);
    totalChecks++;
    if (!ok) begin
      failCount++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task tally_and_finish;
    $display("Checks made %0d, mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ======================================
  // Access tasks
  // A session either commits or leaves, so staging never lingers.
  task cfg(input logic [2:0] n, input logic m, input did_func_t f,
           input logic keep);
    @(posedge clk);
    cfgReq <= '{num: n, mode: m, func: f};
    cfgOpen <= 1'b1;
    @(posedge clk);
    cfgOpen <= 1'b0;
    cfgStageMode <= 1'b1;
    cfgStageFunc <= 1'b1;
    @(posedge clk);
    cfgStageMode <= 1'b0;
    cfgStageFunc <= 1'b0;
    @(negedge clk);
    chk(cfgView === cfgReq && cfgEditing === 1'b1, "staging view");
    @(posedge clk);
    if (keep) begin
      cfgAccept <= 1'b1;
    end else begin
      cfgLeave <= 1'b1;
    end
    @(posedge clk);
    cfgAccept <= 1'b0;
    cfgLeave <= 1'b0;
    @(negedge clk);
    chk(cfgEditing === 1'b0, "editing not closed");
  endtask

  task move(input logic [7:0] m, input logic v);
    @(posedge clk);
    closeReq <= v ? (closeReq | m) : (closeReq & ~m);
  endtask

  // Pulses are ORed over the whole window so latency slips still match.
  task fire(input logic [7:0] m, input logic v, input did_cmd_t e);
    did_cmd_t seen;
    seen = '0;
    move(m, v);
    repeat (6) begin
      @(negedge clk);
      seen = seen | cmd;
    end
    chk(seen === e, "command pulse");
  endtask

  task lvl(input logic [7:0] m, input logic v, input did_force_t ef,
           input logic [7:0] ec);
    move(m, v);
    repeat (6) @(negedge clk);
    chk(frc === ef && ctrlOut === ec, "held outputs");
  endtask

  task pair(input did_func_t f, input did_prof_t bad, input did_prof_t good,
            input did_cmd_t e);
    cfg(3'h3, DID_VPRES_ON, f, 1'b1);
    @(posedge clk);
    profState <= bad;
    fire(8'h08, 1'b1, '0);
    fire(8'h08, 1'b0, '0);
    @(posedge clk);
    profState <= good;
    fire(8'h08, 1'b1, e);
    fire(8'h08, 1'b0, '0);
  endtask

  // ======================================
  // Clock, watchdog and tests
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #20000;
    failCount++;
    tally_and_finish();
  end

  initial begin
    {cfgOpen, cfgStageMode, cfgStageFunc, cfgAccept, cfgLeave} = 5'h00;
    closeReq = 8'h00;
    profState = PROF_IDLE;
    waitSel = 3'h0;
    cfgReq = '0;
    failCount = 0;
    totalChecks = 0;
    rst_b = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk(cmd === DID_CMD_RST && frc === DID_FORCE_RST
        && ctrlOut === DID_ZERO8 && cfgEditing === 1'b0, "reset");
    cfg(3'h0, DID_VPRES_ON, FN_START, 1'b1);
    fire(8'h01, 1'b1, 7'h40);
    fire(8'h01, 1'b0, 7'h00);
    cfg(3'h1, DID_VABS_ON, FN_START, 1'b1);
    fire(8'h02, 1'b1, 7'h00);
    fire(8'h02, 1'b0, 7'h40);
    cfg(3'h2, DID_VPRES_ON, FN_START, 1'b1);
    fire(8'h05, 1'b1, 7'h40);
    fire(8'h05, 1'b0, 7'h00);
    cfg(3'h0, DID_VPRES_ON, FN_PAUSE, 1'b0);
    fire(8'h01, 1'b1, 7'h40);
    fire(8'h01, 1'b0, 7'h00);
    pair(FN_PAUSE, PROF_IDLE, PROF_RUN, 7'h20);
    pair(FN_RESUME, PROF_RUN, PROF_HOLD, 7'h10);
    pair(FN_TERMINATE, PROF_IDLE, PROF_RUN, 7'h08);
    pair(FN_STEP_BACK, PROF_RUN, PROF_HOLD, 7'h02);
    pair(FN_STEP_FWD, PROF_RUN, PROF_HOLD, 7'h01);
    @(posedge clk);
    waitSel <= 3'h3;
    pair(FN_WAIT, PROF_RUN, PROF_WAIT, 7'h04);
    @(posedge clk);
    waitSel <= 3'h2;
    fire(8'h08, 1'b1, 7'h00);
    // Selecting another input drops the staged edit of the first.
    @(posedge clk);
    cfgReq <= '{num: 3'h0, mode: DID_VPRES_ON, func: FN_PAUSE};
    cfgOpen <= 1'b1;
    @(posedge clk);
    cfgOpen <= 1'b0;
    cfgStageFunc <= 1'b1;
    @(posedge clk);
    cfgStageFunc <= 1'b0;
    cfg(3'h4, DID_VPRES_ON, FN_NONE, 1'b1);
    fire(8'h01, 1'b1, 7'h40);
    fire(8'h01, 1'b0, 7'h00);
    fire(8'h10, 1'b1, 7'h00);
    @(posedge clk);
    profState <= PROF_IDLE;
    cfg(3'h5, DID_VPRES_ON, FN_CHAM_OFF, 1'b1);
    lvl(8'h20, 1'b1, 2'b10, 8'h00);
    lvl(8'h20, 1'b0, 2'b00, 8'h00);
    cfg(3'h5, DID_VPRES_ON, FN_ALL_OFF, 1'b1);
    lvl(8'h20, 1'b1, 2'b11, 8'h00);
    lvl(8'h20, 1'b0, 2'b00, 8'h00);
    cfg(3'h5, DID_VPRES_ON, FN_EVT_OFF, 1'b1);
    lvl(8'h20, 1'b1, 2'b01, 8'h00);
    lvl(8'h20, 1'b0, 2'b00, 8'h00);
    cfg(3'h6, DID_VPRES_ON, FN_OUT_CTL, 1'b1);
    lvl(8'h40, 1'b1, 2'b00, 8'h40);
    lvl(8'h40, 1'b0, 2'b00, 8'h00);
    cfg(3'h7, DID_VABS_ON, FN_OUT_CTL, 1'b1);
    lvl(8'h80, 1'b0, 2'b00, 8'h80);
    lvl(8'h80, 1'b1, 2'b00, 8'h00);
    tally_and_finish();
  end
endmodule
